// file: src/rdt_defines.vh
// timing constants and codes for the instruction timing controller
`ifndef RDT_DEFINES_VH
`define RDT_DEFINES_VH

// instruction classes presented with each issue request
`define RDT_CLS_SIMPLE 5'h00
`define RDT_CLS_MOVE_DW 5'h01
`define RDT_CLS_SHIFT_DW 5'h02
`define RDT_CLS_LZC 5'h03
`define RDT_CLS_MUL_WORD 5'h04
`define RDT_CLS_MUL_SDW 5'h05
`define RDT_CLS_MUL_UDW 5'h06
`define RDT_CLS_DIV 5'h07
`define RDT_CLS_BRANCH 5'h08
`define RDT_CLS_DBRANCH 5'h09
`define RDT_CLS_CALL_TRAP 5'h0a
`define RDT_CLS_SOFTWARE 5'h0b
`define RDT_CLS_FRAME 5'h0c
`define RDT_CLS_RETURN 5'h0d
`define RDT_CLS_FETCH 5'h0e
`define RDT_CLS_MEM_WORD 5'h0f
`define RDT_CLS_MEM_DWORD 5'h10
`define RDT_CLS_DSP 5'h11

// execution cycle counts
`define RDT_CYC_ONE 10'h001
`define RDT_CYC_TWO 10'h002
`define RDT_CYC_THREE 10'h003
`define RDT_CYC_FOUR 10'h004
`define RDT_CYC_FIVE 10'h005
`define RDT_CYC_SIX 10'h006
`define RDT_CYC_DIV 10'h024
`define RDT_CYC_ZERO 10'h000
`define RDT_SW_LAT_FREE 10'h004
`define RDT_RET_LAT_FREE 10'h002
`define RDT_RET_RAS_WORDS 4'h2
`define RDT_HW_ZERO 4'h0

// extended dsp operations
`define RDT_DSP_MUL_WORD 4'h0
`define RDT_DSP_MUL_UDW 4'h1
`define RDT_DSP_MUL_SDW 4'h2
`define RDT_DSP_MAC 4'h3
`define RDT_DSP_MAC_DW 4'h4
`define RDT_DSP_MSUB 4'h5
`define RDT_DSP_MSUB_DW 4'h6
`define RDT_DSP_HMAC 4'h7
`define RDT_DSP_HMAC_DW 4'h8
`define RDT_DSP_CMUL 4'h9
`define RDT_DSP_CMAC 4'ha
`define RDT_DSP_CSUM 4'hb
`define RDT_DSP_FFT 4'hc

// dsp latencies, issue to result
`define RDT_DLAT_1 4'h1
`define RDT_DLAT_2 4'h2
`define RDT_DLAT_3 4'h3
`define RDT_DLAT_4 4'h4
`define RDT_DLAT_ZERO 4'h0
`define RDT_DLAT_STEP 4'h1

// address pipeline
`define RDT_LAT_STEP 10'h001
`define RDT_REG_STEP 6'h01

`endif

// file: src/rdt_dsp_unit.v
// multiply/accumulate unit issue and result interlock
`timescale 1ns/10ps
`include "rdt_defines.vh"
module rdt_dsp_unit (
	input wire i_clk,
	input wire i_resetn,
	input wire i_issue,
	input wire [3:0] i_op,
	input wire i_short,
	input wire i_ushort,
	input wire i_is_dsp,
	input wire i_reads_result,
	output wire o_stall
);

	function [3:0] dsp_latency;
		input [3:0] op;
		input short_ops;
		input ushort_ops;
		begin
			case (op)
			`RDT_DSP_MUL_WORD: dsp_latency = short_ops ? `RDT_DLAT_1 : `RDT_DLAT_3;
			`RDT_DSP_MUL_UDW: dsp_latency = ushort_ops ? `RDT_DLAT_2 : `RDT_DLAT_4;
			`RDT_DSP_MUL_SDW: dsp_latency = short_ops ? `RDT_DLAT_3 : `RDT_DLAT_4;
			`RDT_DSP_MAC: dsp_latency = short_ops ? `RDT_DLAT_2 : `RDT_DLAT_3;
			`RDT_DSP_MSUB: dsp_latency = short_ops ? `RDT_DLAT_2 : `RDT_DLAT_3;
			`RDT_DSP_MAC_DW: dsp_latency = short_ops ? `RDT_DLAT_3 : `RDT_DLAT_4;
			`RDT_DSP_MSUB_DW: dsp_latency = short_ops ? `RDT_DLAT_3 : `RDT_DLAT_4;
			`RDT_DSP_HMAC: dsp_latency = `RDT_DLAT_2;
			`RDT_DSP_CSUM: dsp_latency = `RDT_DLAT_2;
			`RDT_DSP_FFT: dsp_latency = `RDT_DLAT_2;
			default: dsp_latency = `RDT_DLAT_4;
			endcase
		end
	endfunction

	reg [3:0] res_cnt_ff;
	reg [3:0] mul_cnt_ff;
	reg [3:0] fin_cnt_ff;
	wire [3:0] lat;
	wire uses_mul;
	wire ends_whole;

	assign lat = dsp_latency(i_op, i_short, i_ushort);
	assign ends_whole = (i_op == `RDT_DSP_CSUM) || (i_op == `RDT_DSP_FFT);
	assign uses_mul = !ends_whole;

	assign o_stall = (i_reads_result && res_cnt_ff != `RDT_DLAT_ZERO) ||
		(i_is_dsp && fin_cnt_ff != `RDT_DLAT_ZERO) ||
		(i_is_dsp && uses_mul && mul_cnt_ff != `RDT_DLAT_ZERO);

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			res_cnt_ff <= `RDT_DLAT_ZERO;
			mul_cnt_ff <= `RDT_DLAT_ZERO;
			fin_cnt_ff <= `RDT_DLAT_ZERO;
		end else if (i_issue) begin
			// the issue cycle itself is not counted, so zero means go
			res_cnt_ff <= lat - `RDT_DLAT_STEP;
			mul_cnt_ff <= (uses_mul && lat > `RDT_DLAT_STEP) ?
				lat - `RDT_DLAT_2 : `RDT_DLAT_ZERO;
			fin_cnt_ff <= ends_whole ? lat - `RDT_DLAT_STEP :
				`RDT_DLAT_ZERO;
		end else begin
			if (res_cnt_ff != `RDT_DLAT_ZERO)
				res_cnt_ff <= res_cnt_ff - `RDT_DLAT_STEP;
			if (mul_cnt_ff != `RDT_DLAT_ZERO)
				mul_cnt_ff <= mul_cnt_ff - `RDT_DLAT_STEP;
			if (fin_cnt_ff != `RDT_DLAT_ZERO)
				fin_cnt_ff <= fin_cnt_ff - `RDT_DLAT_STEP;
		end
	end
endmodule

// file: src/rdt_addr_pipe.v
// two-stage address pipeline with load scoreboard
`timescale 1ns/10ps
`include "rdt_defines.vh"
module rdt_addr_pipe (
	input wire i_clk,
	input wire i_resetn,
	input wire i_push,
	input wire i_push_two,
	input wire i_write,
	input wire i_external,
	input wire [5:0] i_reg,
	input wire [9:0] i_lat,
	input wire [5:0] i_reg_a,
	input wire [5:0] i_reg_b,
	output wire o_room_one,
	output wire o_room_two,
	output wire o_load_hazard
);

	reg v_ff [0:1];
	reg ld_ff [0:1];
	reg [5:0] tag_ff [0:1];
	reg [9:0] cnt_ff [0:1];
	reg last_ext_read_ff;
	reg nv [0:1];
	reg nld [0:1];
	reg [5:0] ntag [0:1];
	reg [9:0] ncnt [0:1];
	reg [9:0] push_cnt;
	wire [1:0] hit;

	// only entries still waiting for data block a reader
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_hit
			assign hit[g] = v_ff[g] && ld_ff[g] &&
				cnt_ff[g] != `RDT_CYC_ZERO &&
				(tag_ff[g] == i_reg_a || tag_ff[g] == i_reg_b);
		end
	endgenerate

	assign o_load_hazard = |hit;
	assign o_room_one = !v_ff[1];
	assign o_room_two = !v_ff[0] && !v_ff[1];

	always @* begin
		// lat holds cycles after the request cycle; -1 plus turnaround
		push_cnt = i_lat - `RDT_LAT_STEP;
		if (i_write && i_external && last_ext_read_ff)
			push_cnt = i_lat;
		if (v_ff[0] && cnt_ff[0] == `RDT_CYC_ZERO) begin
			nv[0] = v_ff[1];
			nld[0] = ld_ff[1];
			ntag[0] = tag_ff[1];
			ncnt[0] = cnt_ff[1];
			nv[1] = 1'b0;
		end else begin
			nv[0] = v_ff[0];
			nld[0] = ld_ff[0];
			ntag[0] = tag_ff[0];
			ncnt[0] = v_ff[0] ? cnt_ff[0] - `RDT_LAT_STEP : cnt_ff[0];
			nv[1] = v_ff[1];
		end
		nld[1] = ld_ff[1];
		ntag[1] = tag_ff[1];
		ncnt[1] = cnt_ff[1];
		if (i_push) begin
			if (!nv[0]) begin
				nv[0] = 1'b1;
				nld[0] = !i_write;
				ntag[0] = i_reg;
				ncnt[0] = push_cnt;
				if (i_push_two) begin
					nv[1] = 1'b1;
					nld[1] = !i_write;
					ntag[1] = i_reg + `RDT_REG_STEP;
					ncnt[1] = i_lat - `RDT_LAT_STEP;
				end
			end else begin
				nv[1] = 1'b1;
				nld[1] = !i_write;
				ntag[1] = i_reg;
				ncnt[1] = push_cnt;
			end
		end
	end

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			v_ff[0] <= 1'b0;
			v_ff[1] <= 1'b0;
			ld_ff[0] <= 1'b0;
			ld_ff[1] <= 1'b0;
			tag_ff[0] <= 6'h00;
			tag_ff[1] <= 6'h00;
			cnt_ff[0] <= `RDT_CYC_ZERO;
			cnt_ff[1] <= `RDT_CYC_ZERO;
			last_ext_read_ff <= 1'b0;
		end else begin
			v_ff[0] <= nv[0];
			v_ff[1] <= nv[1];
			ld_ff[0] <= nld[0];
			ld_ff[1] <= nld[1];
			tag_ff[0] <= ntag[0];
			tag_ff[1] <= ntag[1];
			cnt_ff[0] <= ncnt[0];
			cnt_ff[1] <= ncnt[1];
			if (i_push)
				last_ext_read_ff <= i_external && !i_write;
		end
	end
endmodule

// file: src/rdt_core_timing.v
// instruction timing and interlock controller of the risc/dsp core
`timescale 1ns/10ps
`include "rdt_defines.vh"
module rdt_core_timing (
	input wire i_clk,
	input wire i_resetn,
	input wire i_valid,
	input wire [4:0] i_class,
	input wire [3:0] i_dsp_op,
	input wire i_ops_short,
	input wire i_ops_ushort,
	input wire i_taken,
	input wire i_target_cached,
	input wire [3:0] i_delay_cycles,
	input wire [3:0] i_word_count,
	input wire i_stack_mode,
	input wire i_mem_write,
	input wire i_mem_internal,
	input wire i_mem_ras,
	input wire [5:0] i_mem_reg,
	input wire [5:0] i_reg_a,
	input wire [5:0] i_reg_b,
	input wire i_reads_dsp_result,
	input wire [3:0] i_need_hw,
	input wire [3:0] i_have_hw,
	input wire [3:0] i_setup_cycles,
	input wire [3:0] i_access_cycles,
	input wire [3:0] i_precharge_cycles,
	input wire [3:0] i_ras_cas_cycles,
	input wire [3:0] i_bus_cycles,
	input wire [3:0] i_write_latency,
	input wire [3:0] i_congest_cycles,
	output wire o_ready,
	output wire o_idle_wait,
	output wire o_busy,
	output wire [9:0] o_cycles,
	output wire o_done
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	// latency beyond a free allowance, never negative
	function [9:0] excess;
		input [9:0] lat;
		input [9:0] free;
		begin
			excess = (lat > free) ? lat - free : `RDT_CYC_ZERO;
		end
	endfunction

	function [9:0] widen;
		input [3:0] v;
		begin
			widen = {6'h00, v};
		end
	endfunction

	reg state_ff;
	reg nxt_state;
	reg [9:0] cnt_ff;
	reg [9:0] nxt_cnt;
	reg [9:0] cycles_ff;
	reg done_ff;
	reg nxt_done;
	reg [9:0] cost;
	reg mem_blocked;

	wire [9:0] read_lat;
	wire [9:0] ras_lat;
	wire [9:0] slot_free;
	wire [9:0] write_lat;
	wire [9:0] hw_missing;
	wire [9:0] refill_pairs;
	wire [7:0] word_bus;
	wire [7:0] pair_bus;
	wire [9:0] push_cost;
	wire [9:0] pull_cost;
	wire is_mem;
	wire is_dword;
	wire is_dsp;
	wire accept;
	wire room_one;
	wire room_two;
	wire load_hazard;
	wire dsp_stall;
	wire stall;

	assign ras_lat = widen(i_precharge_cycles) + widen(i_ras_cas_cycles);

	// congestion cycles add to every kind of read, not to stack pushes, pulls or refills
	assign read_lat = i_mem_internal ? `RDT_CYC_ONE + widen(i_congest_cycles) :
		i_mem_ras ? ras_lat + widen(i_access_cycles) + `RDT_CYC_ONE +
			widen(i_congest_cycles) :
		widen(i_setup_cycles) + widen(i_access_cycles) + `RDT_CYC_ONE +
			widen(i_congest_cycles);

	// delay slots hide latency up to their cycles minus one
	assign slot_free = (i_delay_cycles == `RDT_HW_ZERO) ? `RDT_CYC_ZERO :
		widen(i_delay_cycles) - `RDT_CYC_ONE;

	// a zero write latency is still one cycle
	assign write_lat = (i_write_latency == `RDT_HW_ZERO) ? `RDT_CYC_ONE :
		widen(i_write_latency);

	assign word_bus = i_word_count * i_bus_cycles;

	assign push_cost = (i_word_count == `RDT_HW_ZERO) ? `RDT_CYC_ZERO :
		write_lat + {2'b00, word_bus};

	assign pull_cost = (i_word_count == `RDT_HW_ZERO) ? `RDT_CYC_ZERO :
		((i_word_count > `RDT_RET_RAS_WORDS) ? ras_lat : `RDT_CYC_ZERO) +
		{2'b00, word_bus};

	// an odd missing half-word still costs a whole bus access
	assign hw_missing = (i_need_hw > i_have_hw) ?
		widen(i_need_hw) - widen(i_have_hw) : `RDT_CYC_ZERO;
	assign refill_pairs = (hw_missing + `RDT_CYC_ONE) >> 1;
	assign pair_bus = refill_pairs[3:0] * i_bus_cycles;

	assign is_mem = (i_class == `RDT_CLS_MEM_WORD) ||
		(i_class == `RDT_CLS_MEM_DWORD);
	assign is_dword = (i_class == `RDT_CLS_MEM_DWORD);
	assign is_dsp = (i_class == `RDT_CLS_DSP);

	always @* begin
		case (i_class)
		`RDT_CLS_MOVE_DW,
		`RDT_CLS_SHIFT_DW,
		`RDT_CLS_LZC: cost = `RDT_CYC_TWO;
		`RDT_CLS_MUL_WORD:
			cost = i_ops_short ? `RDT_CYC_FOUR : `RDT_CYC_FIVE;
		`RDT_CLS_MUL_SDW:
			cost = i_ops_short ? `RDT_CYC_FIVE : `RDT_CYC_SIX;
		`RDT_CLS_MUL_UDW:
			cost = i_ops_ushort ? `RDT_CYC_FOUR : `RDT_CYC_SIX;
		`RDT_CLS_DIV: cost = `RDT_CYC_DIV;
		`RDT_CLS_BRANCH: begin
			if (!i_taken)
				cost = `RDT_CYC_ONE;
			else if (i_target_cached)
				cost = `RDT_CYC_TWO;
			else
				cost = `RDT_CYC_TWO + read_lat;
		end
		`RDT_CLS_DBRANCH: begin
			if (!i_taken || i_target_cached)
				cost = `RDT_CYC_ONE;
			else
				cost = `RDT_CYC_ONE + excess(read_lat, slot_free);
		end
		`RDT_CLS_CALL_TRAP:
			cost = i_taken ? `RDT_CYC_TWO + read_lat : `RDT_CYC_ONE;
		`RDT_CLS_SOFTWARE:
			cost = `RDT_CYC_SIX + excess(read_lat, `RDT_SW_LAT_FREE);
		`RDT_CLS_FRAME: cost = `RDT_CYC_THREE + push_cost;
		`RDT_CLS_RETURN:
			cost = `RDT_CYC_FOUR + excess(read_lat, `RDT_RET_LAT_FREE) +
				pull_cost;
		`RDT_CLS_FETCH: begin
			if (hw_missing == `RDT_CYC_ZERO)
				cost = `RDT_CYC_ONE;
			else
				cost = `RDT_CYC_ONE + {2'b00, pair_bus};
		end
		`RDT_CLS_MEM_WORD:
			cost = i_stack_mode ? `RDT_CYC_THREE : `RDT_CYC_ONE;
		`RDT_CLS_MEM_DWORD: cost = `RDT_CYC_TWO;
		`RDT_CLS_DSP: cost = `RDT_CYC_ONE;
		default: cost = `RDT_CYC_ONE;
		endcase
	end

	// a double-word needs both stages, so it never halts mid-pair
	always @* begin
		mem_blocked = 1'b0;
		if (is_mem)
			mem_blocked = is_dword ? !room_two : !room_one;
	end

	// waits are idle cycles the program never sees
	assign stall = mem_blocked || load_hazard || dsp_stall;
	assign o_ready = (state_ff == ST_IDLE) && !stall;
	assign o_idle_wait = (state_ff == ST_IDLE) && i_valid && stall;
	assign accept = i_valid && o_ready;

	rdt_addr_pipe u_addr_pipe (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_push(accept && is_mem),
		.i_push_two(is_dword),
		.i_write(i_mem_write),
		.i_external(!i_mem_internal),
		.i_reg(i_mem_reg),
		.i_lat(read_lat),
		.i_reg_a(i_reg_a),
		.i_reg_b(i_reg_b),
		.o_room_one(room_one),
		.o_room_two(room_two),
		.o_load_hazard(load_hazard)
	);

	// non-dsp instructions that do not read its pending result keep flowing while the unit works
	rdt_dsp_unit u_dsp_unit (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_issue(accept && is_dsp),
		.i_op(i_dsp_op),
		.i_short(i_ops_short),
		.i_ushort(i_ops_ushort),
		.i_is_dsp(is_dsp),
		.i_reads_result(i_reads_dsp_result),
		.o_stall(dsp_stall)
	);

	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		case (state_ff)
		ST_IDLE: begin
			if (accept) begin
				if (cost == `RDT_CYC_ONE) begin
					nxt_done = 1'b1;
				end else begin
					nxt_state = ST_EXEC;
					nxt_cnt = cost - `RDT_CYC_ONE;
				end
			end
		end
		ST_EXEC: begin
			if (cnt_ff == `RDT_CYC_ONE) begin
				nxt_state = ST_IDLE;
				nxt_done = 1'b1;
				nxt_cnt = `RDT_CYC_ZERO;
			end else begin
				nxt_cnt = cnt_ff - `RDT_CYC_ONE;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
			nxt_cnt = `RDT_CYC_ZERO;
		end
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= `RDT_CYC_ZERO;
			cycles_ff <= `RDT_CYC_ZERO;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
			if (accept)
				cycles_ff <= cost;
		end
	end

	assign o_busy = (state_ff == ST_EXEC);
	assign o_cycles = cycles_ff;
	assign o_done = done_ff;
endmodule

// file: tb/rdt_core_timing_chk.sv
// port assertions for the instruction timing controller
`timescale 1ns/10ps
`include "rdt_defines.vh"
module rdt_core_timing_chk (
	input wire i_clk,
	input wire i_resetn,
	input wire i_valid,
	input wire [4:0] i_class,
	input wire [3:0] i_dsp_op,
	input wire i_ops_ushort,
	input wire i_taken,
	input wire i_target_cached,
	input wire i_stack_mode,
	input wire i_reads_dsp_result,
	input wire o_ready,
	input wire o_busy,
	input wire [9:0] o_cycles,
	input wire o_done
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire tk = i_valid && o_ready;
	wire tk_dsp = tk && i_class == `RDT_CLS_DSP;
	property p_simple;
		tk && i_class == `RDT_CLS_SIMPLE |=> o_done && o_cycles == 10'h001;
	endproperty
	a_simple: assert property (p_simple) else $error("simple cost");
	property p_two;
		tk && (i_class == `RDT_CLS_MOVE_DW || i_class == `RDT_CLS_LZC ||
		i_class == `RDT_CLS_SHIFT_DW) |=> o_busy && o_cycles == 10'h002
		##1 o_done;
	endproperty
	a_two: assert property (p_two) else $error("two cycle cost");
	property p_mul;
		tk && i_class == `RDT_CLS_MUL_UDW && i_ops_ushort |=>
		o_cycles == 10'h004 ##3 o_done;
	endproperty
	a_mul: assert property (p_mul) else $error("short multiply");
	property p_div;
		tk && i_class == `RDT_CLS_DIV |=> o_busy [*8] ##28
		o_done && o_cycles == 10'h024;
	endproperty
	a_div: assert property (p_div) else $error("divide length");
	property p_branch;
		tk && i_class == `RDT_CLS_BRANCH && i_taken && i_target_cached |=>
		o_cycles == 10'h002 ##1 o_done;
	endproperty
	a_branch: assert property (p_branch) else $error("branch");
	property p_dbranch;
		tk && i_class == `RDT_CLS_DBRANCH && (!i_taken || i_target_cached)
		|=> o_done && !o_busy;
	endproperty
	a_dbranch: assert property (p_dbranch) else $error("delayed");
	property p_stack;
		tk && i_class == `RDT_CLS_MEM_WORD && i_stack_mode |=>
		o_busy && o_cycles == 10'h003 ##2 o_done;
	endproperty
	a_stack: assert property (p_stack) else $error("stack word");
	property p_issue;
		tk_dsp |=> o_done && o_cycles == 10'h001;
	endproperty
	a_issue: assert property (p_issue) else $error("dsp issue");
	property p_reader;
		tk_dsp && i_dsp_op == `RDT_DSP_HMAC |=>
		!(o_ready && i_valid && i_reads_dsp_result);
	endproperty
	a_reader: assert property (p_reader) else $error("result read");
	property p_csum;
		tk_dsp && (i_dsp_op == `RDT_DSP_CSUM || i_dsp_op == `RDT_DSP_FFT)
		|=> !(o_ready && i_valid && i_class == `RDT_CLS_DSP);
	endproperty
	a_csum: assert property (p_csum) else $error("csum blocks dsp");
	c_div: cover property (tk && i_class == `RDT_CLS_DIV);
	c_csum: cover property (tk_dsp && i_dsp_op == `RDT_DSP_CSUM);
	c_stall: cover property (i_valid && !o_ready && !o_busy);
endmodule
bind rdt_core_timing rdt_core_timing_chk i_chk (.i_clk, .i_resetn,
	.i_valid, .i_class, .i_dsp_op, .i_ops_ushort, .i_taken,
	.i_target_cached, .i_stack_mode, .i_reads_dsp_result, .o_ready,
	.o_busy, .o_cycles, .o_done);

// file: tb/rdt_mem_model.sv
// timing of the external memory and i/o bus seen by the core
`timescale 1ns/10ps
module rdt_mem_model (
	input wire [1:0] i_mode,
	input wire [31:0] i_rnd,
	output wire [3:0] o_setup,
	output wire [3:0] o_access,
	output wire [3:0] o_precharge,
	output wire [3:0] o_ras_cas,
	output wire [3:0] o_bus,
	output wire [3:0] o_write_lat,
	output wire [3:0] o_congest
);
	// mode 0 prompt, 1 slow, else drawn; access and bus never zero
	wire [27:0] rnd_cfg = (i_rnd[27:0] & 28'h3333333) | 28'h0100100;
	wire [27:0] cfg = i_mode == 2'h0 ? 28'h0111110 :
		i_mode == 2'h1 ? 28'h2322230 : rnd_cfg;
	assign {o_setup, o_access, o_precharge, o_ras_cas, o_bus, o_write_lat,
		o_congest} = cfg;
endmodule

// file: tb/rdt_core_timing_tb_top.sv
// self-checking bench for the instruction timing controller
`timescale 1ns/10ps
`include "rdt_defines.vh"
module rdt_core_timing_tb_top;
	reg i_clk, i_resetn, i_valid, i_ops_short, i_ops_ushort, i_taken;
	reg i_target_cached, i_stack_mode, i_mem_write, i_mem_internal;
	reg i_mem_ras, i_reads_dsp_result;
	reg [4:0] i_class;
	reg [3:0] i_dsp_op, i_delay_cycles, i_word_count, i_need_hw, i_have_hw;
	reg [5:0] i_mem_reg, i_reg_a, i_reg_b;
	reg [1:0] mode;
	reg [31:0] rnd, r;
	reg [9:0] e;
	wire [3:0] su, ac, pc, rc, bc, wl, cg;
	wire o_ready, o_idle_wait, o_busy, o_done;
	wire [9:0] o_cycles;
	integer num_errors, total_checks, k, n, i;
	rdt_mem_model i_mem (.i_mode(mode), .i_rnd(rnd), .o_setup(su),
		.o_access(ac), .o_precharge(pc), .o_ras_cas(rc), .o_bus(bc),
		.o_write_lat(wl), .o_congest(cg));
	rdt_core_timing i_dut (.i_clk, .i_resetn, .i_valid, .i_class,
		.i_dsp_op, .i_ops_short, .i_ops_ushort, .i_taken, .i_target_cached,
		.i_delay_cycles, .i_word_count, .i_stack_mode, .i_mem_write,
		.i_mem_internal, .i_mem_ras, .i_mem_reg, .i_reg_a, .i_reg_b,
		.i_reads_dsp_result, .i_need_hw, .i_have_hw, .i_setup_cycles(su),
		.i_access_cycles(ac), .i_precharge_cycles(pc), .i_ras_cas_cycles(rc),
		.i_bus_cycles(bc), .i_write_latency(wl), .i_congest_cycles(cg),
		.o_ready, .o_idle_wait, .o_busy, .o_cycles, .o_done);
	function [31:0] lfsr(input [31:0] v);
		integer j;
		begin
			lfsr = v;
			for (j = 0; j < 32; j = j + 1)
				lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		end
	endfunction
	function integer mx0(input integer v);
		mx0 = v > 0 ? v : 0;
	endfunction
	function integer rl();
		rl = (i_mem_internal ? 1 : i_mem_ras ? pc + rc + ac + 1 :
			su + ac + 1) + cg;
	endfunction
	function [9:0] cost();
		integer l, w;
		begin
			l = rl();
			w = i_word_count;
			case (i_class)
			`RDT_CLS_MOVE_DW, `RDT_CLS_SHIFT_DW, `RDT_CLS_LZC: cost = 2;
			`RDT_CLS_MUL_WORD: cost = i_ops_short ? 4 : 5;
			`RDT_CLS_MUL_SDW: cost = i_ops_short ? 5 : 6;
			`RDT_CLS_MUL_UDW: cost = i_ops_ushort ? 4 : 6;
			`RDT_CLS_DIV: cost = 36;
			`RDT_CLS_BRANCH: cost = !i_taken ? 1 : i_target_cached ? 2 : 2 + l;
			// an empty delay slot hides no latency
			`RDT_CLS_DBRANCH: cost = !i_taken || i_target_cached ? 1 :
				1 + mx0(l - mx0(i_delay_cycles - 1));
			`RDT_CLS_CALL_TRAP: cost = i_taken ? 2 + l : 1;
			`RDT_CLS_SOFTWARE: cost = 6 + mx0(l - 4);
			`RDT_CLS_FRAME: cost = 3 + (w > 0 ? (wl > 1 ? wl : 1) + w * bc : 0);
			`RDT_CLS_RETURN: cost = 4 + mx0(l - 2) +
				(w > 0 ? (w > 2 ? pc + rc : 0) + w * bc : 0);
			`RDT_CLS_FETCH: cost = i_have_hw >= i_need_hw ? 1 :
				1 + (i_need_hw - i_have_hw + 1) / 2 * bc;
			`RDT_CLS_MEM_WORD: cost = i_stack_mode ? 3 : 1;
			`RDT_CLS_MEM_DWORD: cost = 2;
			default: cost = 1;
			endcase
		end
	endfunction
	task results;
		begin
			$display("checks %0d errors %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [9:0] got, input [9:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("ERROR %0t got %0d expected %0d", $time, got, exp);
			end
		end
	endtask
	// entered at a falling edge; k counts stalled offers, n cycles to done
	task run;
		begin
			i_valid = 1'b1;
			k = 0;
			#1;
			// bus model outputs have settled by now
			e = cost();
			while (o_ready !== 1'b1 && k < 200) begin
				chk({9'h0, o_idle_wait}, 10'h001);
				@(negedge i_clk);
				#1 k = k + 1;
			end
			@(negedge i_clk);
			n = 1;
			// a one-cycle instruction keeps valid up for the next offer
			if (o_done !== 1'b1)
				i_valid = 1'b0;
			while (o_done !== 1'b1 && n < 200) begin
				@(negedge i_clk);
				n = n + 1;
			end
			if (k == 200 || n == 200) begin
				num_errors = num_errors + 1;
				$display("ERROR %0t wait ran out", $time);
				results;
			end
		end
	endtask
	task pair(input [4:0] c1, input [3:0] o1, input [4:0] c2,
		input [3:0] o2, input integer ek);
		begin
			i_valid = 1'b0;
			repeat (20) @(negedge i_clk);
			i_class = c1;
			i_dsp_op = o1;
			run;
			i_class = c2;
			i_dsp_op = o2;
			run;
			chk(k[9:0], ek[9:0]);
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		num_errors = 0;
		total_checks = 0;
		r = 32'h9db6a799;
		{i_valid, i_ops_short, i_ops_ushort, i_taken, i_target_cached} = 0;
		{i_stack_mode, i_mem_write, i_mem_internal, i_mem_ras} = 0;
		{i_reads_dsp_result, i_class, i_dsp_op, i_delay_cycles} = 0;
		{i_word_count, i_need_hw, i_have_hw, i_mem_reg, i_reg_a} = 0;
		{i_reg_b, mode, rnd} = 0;
		i_resetn = 1'b0;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		i_resetn = 1'b1;
		for (i = 0; i < 300; i = i + 1) begin
			r = lfsr(r);
			i_class = r[4:0] % 5'd18;
			i_dsp_op = r[8:5] % 4'd13;
			{i_delay_cycles, i_word_count, i_need_hw} = r[20:9];
			{i_ops_short, i_ops_ushort, i_taken, i_target_cached} = r[24:21];
			{i_stack_mode, i_mem_write, i_mem_internal, i_mem_ras} = r[28:25];
			r = lfsr(r);
			{i_have_hw, i_mem_reg, i_reg_a, i_reg_b} = r[21:0];
			{i_reads_dsp_result, mode} = r[24:22];
			rnd = lfsr(r);
			run;
			chk(n[9:0], e);
			chk(o_cycles, e);
		end
		// quiet hazards so each pair sees only its own interlock
		{i_reads_dsp_result, i_stack_mode, i_mem_write, i_valid} = 4'h0;
		{i_mem_internal, i_mem_ras, mode} = 4'h1;
		{i_mem_reg, i_reg_b} = {6'h05, 6'h3e};
		i_reg_a = 6'h05;
		// let the bus model settle before its latency is read
		@(negedge i_clk);
		pair(`RDT_CLS_MEM_WORD, 0, `RDT_CLS_SIMPLE, 0, rl() - 1);
		i_reg_a = 6'h3f;
		i_valid = 1'b0;
		repeat (20) @(negedge i_clk);
		i_class = `RDT_CLS_MEM_DWORD;
		run;
		run;
		chk({9'h0, k > 0}, 10'h001);
		pair(`RDT_CLS_DSP, `RDT_DSP_CMUL, `RDT_CLS_DSP, `RDT_DSP_MUL_WORD,
			2);
		pair(`RDT_CLS_DSP, `RDT_DSP_CSUM, `RDT_CLS_DSP, `RDT_DSP_HMAC,
			1);
		pair(`RDT_CLS_DSP, `RDT_DSP_FFT, `RDT_CLS_DSP, `RDT_DSP_CMAC,
			1);
		i_reads_dsp_result = 1'b1;
		pair(`RDT_CLS_DSP, `RDT_DSP_HMAC, `RDT_CLS_SIMPLE, 0, 1);
		pair(`RDT_CLS_DSP, `RDT_DSP_HMAC_DW, `RDT_CLS_SIMPLE, 0, 3);
		i_ops_ushort = 1'b1;
		pair(`RDT_CLS_DSP, `RDT_DSP_MUL_UDW, `RDT_CLS_SIMPLE, 0, 1);
		i_ops_ushort = 1'b0;
		pair(`RDT_CLS_DSP, `RDT_DSP_MUL_UDW, `RDT_CLS_SIMPLE, 0, 3);
		results;
	end
endmodule
